//--- logic/pll_divider_timestamp_config.sv
// Module: timestamp, refclk output and PLL feedback divider configuration registers
`default_nettype none
module pll_divider_timestamp_config (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pll_enable_pin,
    input wire logic loop_reset_control,
    input wire logic vco_tick,
    output logic stamp_receiver_on,
    output logic stamp_input_pecl_select,
    output logic loop_refclk_out_on,
    output logic [6:0] oscillator_bias_level,
    output logic sample_tick,
    output logic pfd_feedback_tick
);
    pll_cfg_pkg::reg_req_s req; // Bundled register request
    pll_cfg_pkg::div_ratio_s ratio; // Ratios decoded from the fields
    logic [7:0] stamp_ctrl_r; // Timestamp input control
    logic [7:0] refclk_ctrl_r; // Reference clock output control
    logic [7:0] div_fs_r; // First and second divider codes
    logic [7:0] div_third_r; // Third divider value
    logic [7:0] bias_r; // Oscillator bias
    logic [7:0] rdata_nxt; // Read mux result
    logic pll_en_meta_r; // Enable pin, first synchroniser stage
    logic pll_en_sync_r; // Enable pin, synchronised
    logic first_tick; // First divider output
    logic [1:0] first_code; // First divider code field
    logic [1:0] second_code; // Second divider code field
    logic wr_stamp; // Write strobe for timestamp control
    logic wr_refclk; // Write strobe for reference clock control
    logic wr_div_fs; // Write strobe for first and second codes
    logic wr_div_third; // Write strobe for third divider value
    logic wr_bias; // Write strobe for oscillator bias

    // Port signals gathered so decode and write logic share one bundle
    assign req = '{wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

    ////////////////////////////////////////////////////////////////////////////
    // Write decode: one strobe per mapped offset, unmapped writes hit nothing
    assign wr_stamp = req.wr && (req.addr == pll_cfg_pkg::OFS_STAMP_CTRL);
    assign wr_refclk = req.wr && (req.addr == pll_cfg_pkg::OFS_REFCLK_CTRL);
    assign wr_div_fs = req.wr && (req.addr == pll_cfg_pkg::OFS_DIV_FIRST_SECOND);
    assign wr_div_third = req.wr && (req.addr == pll_cfg_pkg::OFS_DIV_THIRD);
    assign wr_bias = req.wr && (req.addr == pll_cfg_pkg::OFS_OSCILLATOR_BIAS_LEVEL);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, one process per register. Reserved bits are stored as
    // written so reads echo them; keeping them at reset value is the writer's
    // duty, and storing them costs a few flops but keeps readback honest  see [R1]

    // Timestamp control: receiver enable and input mode
    always_ff @(posedge clk) begin
        if (rst) begin
            stamp_ctrl_r <= pll_cfg_pkg::RST_STAMP_CTRL;
        end else if (wr_stamp) begin
            stamp_ctrl_r <= req.wdata;
        end
    end

    // Reference clock output control; it resets enabled so the output
    // runs before any register access whenever the PLL enable pin is high
    always_ff @(posedge clk) begin
        if (rst) begin
            refclk_ctrl_r <= pll_cfg_pkg::RST_REFCLK_CTRL;
        end else if (wr_refclk) begin
            refclk_ctrl_r <= req.wdata;
        end
    end

    // First and second divider codes; changes are expected only under
    // loop reset, a change in mid-run may give one short period  see [R8]
    always_ff @(posedge clk) begin
        if (rst) begin
            div_fs_r <= pll_cfg_pkg::RST_DIV_FIRST_SECOND;
        end else if (wr_div_fs) begin
            div_fs_r <= req.wdata;
        end
    end

    // Third divider value; same loop reset expectation as above  see [R8]
    always_ff @(posedge clk) begin
        if (rst) begin
            div_third_r <= pll_cfg_pkg::RST_DIV_THIRD;
        end else if (wr_div_third) begin
            div_third_r <= req.wdata;
        end
    end

    // Bias is taken as written; 0x4A is software's job  see [R9]
    always_ff @(posedge clk) begin
        if (rst) begin
            bias_r <= pll_cfg_pkg::RST_OSCILLATOR_BIAS_LEVEL;
        end else if (wr_bias) begin
            bias_r <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero
    always_comb begin
        if (req.addr == pll_cfg_pkg::OFS_STAMP_CTRL) begin
            rdata_nxt = stamp_ctrl_r;
        end else if (req.addr == pll_cfg_pkg::OFS_REFCLK_CTRL) begin
            rdata_nxt = refclk_ctrl_r;
        end else if (req.addr == pll_cfg_pkg::OFS_DIV_FIRST_SECOND) begin
            rdata_nxt = div_fs_r;
        end else if (req.addr == pll_cfg_pkg::OFS_DIV_THIRD) begin
            rdata_nxt = div_third_r;
        end else if (req.addr == pll_cfg_pkg::OFS_OSCILLATOR_BIAS_LEVEL) begin
            rdata_nxt = bias_r;
        end else begin
            rdata_nxt = pll_cfg_pkg::UNMAPPED_READ;
        end
    end

    // Read data registered, valid one cycle after the address.
    // One flop keeps the read path short; the price is one cycle of
    // latency that the master must allow for
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable pin comes from outside the clock domain: two flops first.
    // Only the second stage is read; the first may still be settling.
    // Reset holds both low, so the output stays off for two edges after
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_en_meta_r <= 1'b0;
            pll_en_sync_r <= 1'b0;
        end else begin
            pll_en_meta_r <= pll_enable_pin;
            pll_en_sync_r <= pll_en_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered control outputs; they follow the registers one edge
    // later, so a write shows on the pins at the second edge, and every
    // output leaves straight from a flop with no decode glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            stamp_receiver_on <= 1'b0;
            stamp_input_pecl_select <= 1'b0;
            loop_refclk_out_on <= 1'b0;
            oscillator_bias_level <= 7'h00;
        end else begin
            stamp_receiver_on <= stamp_ctrl_r[pll_cfg_pkg::BIT_STAMP_ON]; // see [R2]
            stamp_input_pecl_select <= stamp_ctrl_r[pll_cfg_pkg::BIT_STAMP_PECL]; // see [R3]
            // Enable resets to one, so until the bit is cleared the output follows the PLL enable alone
            loop_refclk_out_on <= refclk_ctrl_r[pll_cfg_pkg::BIT_REFCLK_ON]
                && pll_en_sync_r; // see [R4]
            oscillator_bias_level <= bias_r[pll_cfg_pkg::BIAS_LSB +: pll_cfg_pkg::BIAS_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode codes to ratios; reserved code 3 falls back to the reset ratio.
    // A user who writes code 3 gets the reset rate rather than a stalled
    // chain, which is the safer of the two outcomes
    assign first_code = div_fs_r[pll_cfg_pkg::FIRST_LSB +: pll_cfg_pkg::CODE_W];
    assign second_code = div_fs_r[pll_cfg_pkg::SECOND_LSB +: pll_cfg_pkg::CODE_W];

    always_comb begin
        case (first_code) // see [R6]
            pll_cfg_pkg::CODE1: ratio.first = pll_cfg_pkg::FIRST_CODE1_RATIO;
            pll_cfg_pkg::CODE2: ratio.first = pll_cfg_pkg::FIRST_CODE2_RATIO;
            default: ratio.first = pll_cfg_pkg::FIRST_CODE0_RATIO;
        endcase
        case (second_code) // see [R5]
            pll_cfg_pkg::CODE1: ratio.second = pll_cfg_pkg::SECOND_CODE1_RATIO;
            pll_cfg_pkg::CODE2: ratio.second = pll_cfg_pkg::SECOND_CODE2_RATIO;
            default: ratio.second = pll_cfg_pkg::SECOND_CODE0_RATIO;
        endcase
        // Literal value; zero is unsupported and is run as divide by one  see [R7]
        ratio.third = div_third_r[pll_cfg_pkg::THIRD_LSB +: pll_cfg_pkg::THIRD_W];
        if (ratio.third == 6'h00) begin
            ratio.third = pll_cfg_pkg::MIN_RATIO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider chain: VCO -> first -> second (sampling) -> third (feedback),
    // so feedback rate is VCO over the ratio product  see [R10]
    // Each stage adds one cycle of latency; only rates matter here.
    // All three stages share the loop reset, so releasing it restarts the
    // chain from a known phase; a change made outside it may shorten one
    // period while the counters wrap at the new terminal count.
    tick_divider u_first (
        .clk(clk),
        .rst(rst),
        .hold(loop_reset_control),
        .tick_in(vco_tick),
        .ratio(ratio.first),
        .tick_out(first_tick)
    );

    tick_divider u_second (
        .clk(clk),
        .rst(rst),
        .hold(loop_reset_control),
        .tick_in(first_tick),
        .ratio(ratio.second),
        .tick_out(sample_tick)
    );

    tick_divider u_third (
        .clk(clk),
        .rst(rst),
        .hold(loop_reset_control),
        .tick_in(sample_tick),
        .ratio(ratio.third),
        .tick_out(pfd_feedback_tick)
    );
endmodule : pll_divider_timestamp_config
`default_nettype wire

//--- logic/pll_cfg_pkg.sv
// Package: register map, field layout, reset values and divider codes of the PLL config block
// Summary of operation
// [R1] Software rewrites reserved fields with reset values
// [R2] Timestamp control bit 0 enables stamp receiver
// [R3] Timestamp control bit 1 selects PECL input
// [R4] Refclk out driven when enabled and PLL on
// [R5] Second divider codes 0,1,2 give 1,2,4
// [R6] First divider codes 0,1,2 give 5,4,3
// [R7] Third divider divides sampling clock by value
// [R8] Software holds PLL reset before divider changes
// [R9] Software programs oscillator bias to 0x4A
// [R10] Feedback clock is VCO over ratio product
`default_nettype none
package pll_cfg_pkg;
    // Register offsets on the parallel register port
    localparam logic [7:0] OFS_STAMP_CTRL = 8'h3B;
    localparam logic [7:0] OFS_REFCLK_CTRL = 8'h3C;
    localparam logic [7:0] OFS_DIV_FIRST_SECOND = 8'h3D;
    localparam logic [7:0] OFS_DIV_THIRD = 8'h3E;
    localparam logic [7:0] OFS_OSCILLATOR_BIAS_LEVEL = 8'h3F;
    // Reset values
    localparam logic [7:0] RST_STAMP_CTRL = 8'h00;
    localparam logic [7:0] RST_REFCLK_CTRL = 8'h01;
    localparam logic [7:0] RST_DIV_FIRST_SECOND = 8'h00;
    localparam logic [7:0] RST_DIV_THIRD = 8'h20;
    localparam logic [7:0] RST_OSCILLATOR_BIAS_LEVEL = 8'h4F;
    // Value read at an unmapped offset
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Field positions
    localparam int BIT_STAMP_ON = 0;
    localparam int BIT_STAMP_PECL = 1;
    localparam int BIT_REFCLK_ON = 0;
    localparam int FIRST_LSB = 0;
    localparam int SECOND_LSB = 2;
    localparam int THIRD_LSB = 0;
    localparam int BIAS_LSB = 0;
    localparam int CODE_W = 2;
    localparam int THIRD_W = 6;
    localparam int BIAS_W = 7;
    // Divider ratios, all at the width of the divider ratio port
    localparam logic [5:0] FIRST_CODE0_RATIO = 6'h05;
    localparam logic [5:0] FIRST_CODE1_RATIO = 6'h04;
    localparam logic [5:0] FIRST_CODE2_RATIO = 6'h03;
    localparam logic [5:0] SECOND_CODE0_RATIO = 6'h01;
    localparam logic [5:0] SECOND_CODE1_RATIO = 6'h02;
    localparam logic [5:0] SECOND_CODE2_RATIO = 6'h04;
    localparam logic [5:0] MIN_RATIO = 6'h01;
    // Divider codes
    localparam logic [1:0] CODE0 = 2'h0;
    localparam logic [1:0] CODE1 = 2'h1;
    localparam logic [1:0] CODE2 = 2'h2;

    // Register port request carried as one bundle
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Resolved ratios of the three feedback dividers
    typedef struct packed {
        logic [5:0] first;
        logic [5:0] second;
        logic [5:0] third;
    } div_ratio_s;
endpackage : pll_cfg_pkg
`default_nettype wire

//--- logic/tick_divider.sv
// Module: divides a one-cycle tick stream by a programmable ratio
`default_nettype none
module tick_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic tick_in,
    input wire logic [5:0] ratio,
    output logic tick_out
);
    logic [5:0] count_r; // Ticks seen in the current period
    logic [5:0] last; // Terminal count for the ratio

    // A ratio of zero would wrap only at 63, so treat it as one
    assign last = (ratio == 6'h00) ? 6'h00 : ratio - 6'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Period counter, cleared while the loop is held in reset
    always_ff @(posedge clk) begin
        if (rst || hold) begin
            count_r <= 6'h00;
        end else if (tick_in) begin
            // Wrap at terminal count; a ratio shrunk mid-period also wraps
            if (count_r >= last) begin
                count_r <= 6'h00;
            end else begin
                count_r <= count_r + 6'h01;
            end
        end
    end

    // Registered output pulse, one per completed period
    always_ff @(posedge clk) begin
        if (rst || hold) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && (count_r >= last);
        end
    end
endmodule : tick_divider
`default_nettype wire

//--- dv/pll_cfg_asserts.sv
// Checker: port-level assertions for the PLL divider and timestamp config block
`default_nettype none
module pll_cfg_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic pll_enable_pin,
    input wire logic loop_reset_control,
    input wire logic stamp_receiver_on,
    input wire logic stamp_input_pecl_select,
    input wire logic loop_refclk_out_on,
    input wire logic [6:0] oscillator_bias_level,
    input wire logic sample_tick,
    input wire logic pfd_feedback_tick
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Decoded accesses; reads need no write in the same cycle
    wire logic at_stamp = reg_addr == pll_cfg_pkg::OFS_STAMP_CTRL;
    wire logic at_bias = reg_addr == pll_cfg_pkg::OFS_OSCILLATOR_BIAS_LEVEL;
    wire logic at_refclk = reg_addr == pll_cfg_pkg::OFS_REFCLK_CTRL;
    //////////////////////////////////////////////////////////////////
    // Register takes the write at one edge, the output flop at the next,
    // so a written value is seen on the pins two edges on
    AST_STAMP_ON: assert property (reg_wr && at_stamp |-> ##2
        stamp_receiver_on == $past(reg_wdata[0], 2)) else $error("stamp enable wrong");
    AST_STAMP_PECL: assert property (reg_wr && at_stamp |-> ##2
        stamp_input_pecl_select == $past(reg_wdata[1], 2)) else $error("pecl select wrong");
    AST_STAMP_READ: assert property (!reg_wr && at_stamp |=>
        reg_rdata[1:0] == {stamp_input_pecl_select, stamp_receiver_on})
        else $error("stamp readback differs from outputs");
    AST_BIAS_WRITE: assert property (reg_wr && at_bias |-> ##2
        oscillator_bias_level == $past(reg_wdata[6:0], 2)) else $error("bias wrong");
    AST_BIAS_READ: assert property (!reg_wr && at_bias |=>
        reg_rdata[6:0] == oscillator_bias_level) else $error("bias readback wrong");
    // Synchroniser plus output flop: five low samples must clear the output
    AST_REFCLK_PIN: assert property (!pll_enable_pin [*5] |->
        !loop_refclk_out_on) else $error("refclk on with pin low");
    AST_REFCLK_BIT: assert property (reg_wr && at_refclk && !reg_wdata[0] |-> ##2
        !loop_refclk_out_on) else $error("refclk on with bit clear");
    AST_LOOP_HOLD: assert property (loop_reset_control |=>
        !sample_tick && !pfd_feedback_tick) else $error("tick during loop reset");
    // Smallest first ratio is 3, so pulses are at least three cycles apart
    AST_SAMPLE_GAP: assert property (sample_tick |=> !sample_tick [*2])
        else $error("sample ticks too close");
    AST_PFD_GAP: assert property (pfd_feedback_tick |=> !pfd_feedback_tick [*2])
        else $error("feedback ticks too close");
endmodule : pll_cfg_asserts
bind pll_divider_timestamp_config pll_cfg_asserts i_pll_cfg_asserts (
    .clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .pll_enable_pin,
    .loop_reset_control, .stamp_receiver_on, .stamp_input_pecl_select,
    .loop_refclk_out_on, .oscillator_bias_level, .sample_tick, .pfd_feedback_tick
);
`default_nettype wire

//--- dv/tb_top.sv
// Testbench: register port and divider chain checks for the PLL config block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic pll_enable_pin = 1'b1;
    logic loop_reset_control = 1'b0;
    logic vco_tick = 1'b0;
    logic [7:0] reg_rdata;
    logic stamp_receiver_on;
    logic stamp_input_pecl_select;
    logic loop_refclk_out_on;
    logic [6:0] oscillator_bias_level;
    logic sample_tick;
    logic pfd_feedback_tick;
    int fail_count = 0;
    int comparisons = 0;
    // Reset contents in offset order 0x3B..0x3F
    logic [7:0] rst_val [5] = '{8'h00, 8'h01, 8'h00, 8'h20, 8'h4F};
    pll_divider_timestamp_config i_pll_divider_timestamp_config (
        .clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .pll_enable_pin,
        .loop_reset_control, .vco_tick, .stamp_receiver_on, .stamp_input_pecl_select,
        .loop_refclk_out_on, .oscillator_bias_level, .sample_tick, .pfd_feedback_tick
    );
    // 100 MHz clock
    initial forever #5 clk = ~clk;
    //////////////////////////////////////////////////////////////////
    // One edge, then let its updates land before sampling
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Write strobe lasts exactly one taking edge; the idle edge after it
    // lets the registered outputs follow and keeps strobes apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
        reg_wr = 1'b0;
        step();
    endtask : wr
    // Read data is registered: valid after the edge that samples the offset
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        step();
        chk(reg_rdata, exp);
    endtask : rd
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Program the chain under loop reset, then time two feedback pulses
    task automatic div_case(input logic [1:0] v, input logic [1:0] p, input logic [5:0] n);
        int ratio;
        int cyc;
        int start;
        int smp;
        ratio = (v == 2'h0 ? 5 : v == 2'h1 ? 4 : 3) * (1 << p) * n;
        loop_reset_control = 1'b1;
        wr(8'h3D, {4'h0, p, v});
        wr(8'h3E, {2'h0, n});
        loop_reset_control = 1'b0;
        cyc = 0;
        smp = 0;
        // Skip to the first pulse; the bound covers the largest ratio tried
        while (pfd_feedback_tick !== 1'b1 && cyc < 1000) begin
            step();
            cyc++;
        end
        // Period runs from this pulse to the next one
        start = cyc;
        do begin
            step();
            cyc++;
            smp += (sample_tick === 1'b1);
        end while (pfd_feedback_tick !== 1'b1 && cyc < 2000);
        if (cyc >= 2000) begin
            fail_count++;
            tally_and_finish();
        end else begin
            chk(16'(cyc - start), 16'(ratio));
            chk(16'(smp), 16'(n));
        end
        $display("test divider ratio %0d done", ratio);
    endtask : div_case
    //////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        vco_tick = 1'b1;
        // Reset values, then unmapped offsets on both sides of the map
        for (int i = 0; i < 5; i++) begin
            rd(8'h3B + 8'(i), rst_val[i]);
        end
        rd(8'h3A, 8'h00);
        rd(8'h40, 8'h00);
        $display("test reset values done");
        // Every combination of receiver enable and input mode
        for (int i = 0; i < 4; i++) begin
            wr(8'h3B, 8'(i));
            chk({stamp_input_pecl_select, stamp_receiver_on}, 16'(i));
            rd(8'h3B, 8'(i));
        end
        wr(8'h3F, 8'h4A);
        chk(oscillator_bias_level, 16'h004A);
        rd(8'h3F, 8'h4A);
        $display("test stamp and bias done");
        // Refclk output needs both the enable bit and the PLL enable pin
        chk(loop_refclk_out_on, 16'h0001);
        pll_enable_pin = 1'b0;
        repeat (5) step();
        chk(loop_refclk_out_on, 16'h0000);
        pll_enable_pin = 1'b1;
        repeat (5) step();
        chk(loop_refclk_out_on, 16'h0001);
        wr(8'h3C, 8'h00);
        step();
        chk(loop_refclk_out_on, 16'h0000);
        wr(8'h3C, 8'h01);
        $display("test refclk done");
        // Every valid code of both coded dividers, third at default and limit
        div_case(2'h0, 2'h0, 6'h20);
        div_case(2'h1, 2'h1, 6'h02);
        div_case(2'h2, 2'h2, 6'h03);
        div_case(2'h2, 2'h0, 6'h3F);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
